/* File: rtl/slp_sector_lock.sv */
// sector lock protection: persistent and temporary per-sector locks behind a serial link
//
// Overview of operation
// - each sector has a persistent lock bit, and a 0 there blocks program and erase.
// - persistent lock bits survive every reset and only the erase command returns them to 1.
// - the persistent write command clears the addressed sector's bit after a byte program time.
// - the persistent erase command sets every persistent bit to 1 after a sector erase time.
// - each sector has a temporary lock bit, and a 1 there blocks program and erase.
// - every reset clears all temporary lock state to 0.
// - the temporary write command loads the addressed lock register, write lock 1 protects.
// - separate read commands return the persistent bits and the temporary registers.
// - the temporary register is 8 bits, bit 0 write lock, bit 1 lock-down, 7:2 read 0.
// - a temporary write is carried out only while the lock-down bit is 0.
// - lock-down starts at 0 and once 1 freezes both temporary bits until a reset.
// - write lock starts at 0 and while 1 stops program and erase on that sector.
// - with the global freeze bit at 0 persistent bit writes and erases are rejected.
// - first and last sectors have temporary locks per 4KB subsector, persistent per sector.
`timescale 1ns/1ps
module slp_sector_lock
    import slp_pkg::*;
#(
    parameter int SECTORS = SLP_SECTORS,
    parameter int PROG_CYC = SLP_PROG_CYC,
    parameter int ERASE_CYC = SLP_ERASE_CYC
)
(
    // clock, reset, enable
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_clk_en,
    input wire logic i_soft_reset,
    // serial link pins
    input wire logic i_spi_sck,
    input wire logic i_spi_cs_n,
    input wire logic i_spi_mosi,
    output logic o_spi_miso,
    output logic o_spi_miso_oe,
    // global freeze bit value, 0 freezes persistent bits
    input wire logic i_global_freeze,
    // program/erase permission query
    input wire slp_pe_req_t i_pe_req,
    output slp_pe_rsp_t o_pe_rsp,
    // persistent operation in progress
    output logic o_busy
);

    localparam int SW = $clog2(SECTORS);
    localparam int NT = SECTORS + 2 * (SLP_SUBS_PER_EDGE - 1);
    localparam int TW = $clog2(NT);

    // sector number of an address
    function automatic logic [SW-1:0] sect_of(input logic [31:0] a);
        sect_of = a[SLP_SECT_LSB +: SW];
    endfunction

    // temporary lock index: edge sectors split into subsectors
    function automatic logic [TW-1:0] tmp_idx(input logic [31:0] a);
        logic [SW-1:0] s;
        logic [3:0] sub;
        s = a[SLP_SECT_LSB +: SW];
        sub = a[SLP_SUB_LSB +: 4];
        if (s == '0)
            tmp_idx = TW'(sub);
        else if (s == SW'(SECTORS - 1))
            tmp_idx = TW'(SECTORS + SLP_SUBS_PER_EDGE - 2) + TW'(sub);
        else
            tmp_idx = TW'(s) + TW'(SLP_SUBS_PER_EDGE - 1);
    endfunction

    // storage
    logic nv_bits [SECTORS];
    logic [1:0] tmp_reg [NT];

    // synchronisers and filtered link levels
    logic [2:0] sck_sync_reg;
    logic [2:0] cs_sync_reg;
    logic [2:0] mosi_sync_reg;
    logic sck_reg;
    logic cs_n_reg;
    logic mosi_reg;

    // frame decoder
    slp_state_t st_reg;
    logic [2:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic [7:0] cmd_reg;
    logic [31:0] addr_reg;
    logic [1:0] addr_cnt_reg;
    logic [7:0] data_reg;
    logic [7:0] out_reg;
    logic addr_ok_reg;
    logic data_ok_reg;

    // persistent operation timer
    logic [31:0] busy_cnt_reg;
    logic pend_erase_reg;
    logic [SW-1:0] pend_sect_reg;

    logic sck_rise;
    logic sck_fall;
    logic cs_end;
    logic byte_done;
    logic [7:0] byte_in;
    logic exec_wr_tmp;
    logic exec_wr_nv;
    logic exec_er_nv;

    // three-stage synchronisers; a level counts once stages two and three agree
    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            sck_sync_reg <= 3'h0;
            cs_sync_reg <= 3'h7;
            mosi_sync_reg <= 3'h0;
            sck_reg <= 1'b0;
            cs_n_reg <= 1'b1;
            mosi_reg <= 1'b0;
        end
        else if (i_clk_en)
        begin
            sck_sync_reg <= {sck_sync_reg[1:0], i_spi_sck};
            cs_sync_reg <= {cs_sync_reg[1:0], i_spi_cs_n};
            mosi_sync_reg <= {mosi_sync_reg[1:0], i_spi_mosi};
            if (sck_sync_reg[1] == sck_sync_reg[2])
                sck_reg <= sck_sync_reg[2];
            if (cs_sync_reg[1] == cs_sync_reg[2])
                cs_n_reg <= cs_sync_reg[2];
            if (mosi_sync_reg[1] == mosi_sync_reg[2])
                mosi_reg <= mosi_sync_reg[2];
        end
    end

    // edges of the filtered link clock, only counted inside a frame
    assign sck_rise = !cs_n_reg && (sck_sync_reg[1] == sck_sync_reg[2])
                      && sck_sync_reg[2] && !sck_reg;
    assign sck_fall = !cs_n_reg && (sck_sync_reg[1] == sck_sync_reg[2])
                      && !sck_sync_reg[2] && sck_reg;
    assign cs_end = (cs_sync_reg[1] == cs_sync_reg[2]) && cs_sync_reg[2] && !cs_n_reg;
    assign byte_in = {shift_reg[6:0], mosi_reg};
    assign byte_done = sck_rise && (bit_cnt_reg == 3'h7);

    // frame end actions; a torn last byte drops any command, a busy timer drops the persistent ones
    assign exec_wr_tmp = cs_end && (cmd_reg == SLP_CMD_WR_TMP) && data_ok_reg
                         && (bit_cnt_reg == 3'h0);
    assign exec_wr_nv = cs_end && (cmd_reg == SLP_CMD_WR_NV) && addr_ok_reg
                        && (bit_cnt_reg == 3'h0) && (busy_cnt_reg == '0)
                        && i_global_freeze;
    assign exec_er_nv = cs_end && (cmd_reg == SLP_CMD_ER_NV) && (st_reg == SLP_ST_SKIP)
                        && (bit_cnt_reg == 3'h0) && (busy_cnt_reg == '0)
                        && i_global_freeze;

    // frame decoder: opcode, four address bytes (none for erase), then data in for a temporary write or data out for a read
    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            st_reg <= SLP_ST_CMD;
            bit_cnt_reg <= 3'h0;
            shift_reg <= 8'h00;
            cmd_reg <= 8'h00;
            addr_reg <= 32'h0000_0000;
            addr_cnt_reg <= 2'h0;
            data_reg <= 8'h00;
            addr_ok_reg <= 1'b0;
            data_ok_reg <= 1'b0;
        end
        else if (i_clk_en)
        begin
            if (cs_n_reg)
            begin
                st_reg <= SLP_ST_CMD;
                bit_cnt_reg <= 3'h0;
                addr_cnt_reg <= 2'h0;
                addr_ok_reg <= 1'b0;
                data_ok_reg <= 1'b0;
                if (cs_sync_reg[1] == cs_sync_reg[2] && !cs_sync_reg[2])
                    cmd_reg <= 8'h00;
            end
            else if (sck_rise)
            begin
                bit_cnt_reg <= bit_cnt_reg + 3'h1;
                shift_reg <= byte_in;
                if (byte_done)
                begin
                    unique case (st_reg)
                        SLP_ST_CMD:
                        begin
                            cmd_reg <= byte_in;
                            if (byte_in == SLP_CMD_WR_TMP || byte_in == SLP_CMD_RD_TMP
                                || byte_in == SLP_CMD_RD_NV || byte_in == SLP_CMD_WR_NV)
                                st_reg <= SLP_ST_ADDR;
                            else
                                st_reg <= SLP_ST_SKIP;
                        end
                        SLP_ST_ADDR:
                        begin
                            addr_reg <= {addr_reg[23:0], byte_in};
                            addr_cnt_reg <= addr_cnt_reg + 2'h1;
                            if (addr_cnt_reg == 2'(SLP_ADDR_BYTES - 1))
                            begin
                                addr_ok_reg <= 1'b1;
                                if (cmd_reg == SLP_CMD_WR_TMP)
                                    st_reg <= SLP_ST_DATA;
                                else if (cmd_reg == SLP_CMD_WR_NV)
                                    st_reg <= SLP_ST_SKIP;
                                else
                                    st_reg <= SLP_ST_READ;
                            end
                        end
                        SLP_ST_DATA:
                        begin
                            data_reg <= byte_in;
                            data_ok_reg <= 1'b1;
                            st_reg <= SLP_ST_SKIP;
                        end
                        SLP_ST_READ,
                        SLP_ST_SKIP:
                            st_reg <= st_reg;
                    endcase
                end
            end
        end
    end

    // read data out: loaded as the address completes, rotated so it repeats
    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            out_reg <= 8'h00;
            o_spi_miso <= 1'b0;
            o_spi_miso_oe <= 1'b0;
        end
        else if (i_clk_en)
        begin
            o_spi_miso_oe <= !cs_n_reg && (st_reg == SLP_ST_READ);
            if (byte_done && st_reg == SLP_ST_ADDR && addr_cnt_reg == 2'(SLP_ADDR_BYTES - 1))
            begin
                if (cmd_reg == SLP_CMD_RD_TMP)
                    out_reg <= {6'h00, tmp_reg[tmp_idx({addr_reg[23:0], byte_in})]};
                else
                    out_reg <= nv_bits[sect_of({addr_reg[23:0], byte_in})] ?
                               SLP_NV_RD_OPEN : SLP_NV_RD_LOCKED;
            end
            else if (sck_fall && st_reg == SLP_ST_READ)
            begin
                o_spi_miso <= out_reg[7];
                out_reg <= {out_reg[6:0], out_reg[7]};
            end
        end
    end

    // temporary locks: cleared by any reset, frozen by lock-down
    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            for (int i = 0; i < NT; i++)
                tmp_reg[i] <= SLP_TMP_RESET;
        end
        else if (i_clk_en)
        begin
            if (i_soft_reset)
            begin
                for (int i = 0; i < NT; i++)
                    tmp_reg[i] <= SLP_TMP_RESET;
            end
            else if (exec_wr_tmp && !tmp_reg[tmp_idx(addr_reg)][SLP_LDOWN_BIT])
                tmp_reg[tmp_idx(addr_reg)] <= data_reg[1:0];
        end
    end

    // persistent operation timer; the change lands when the time has run out
    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            busy_cnt_reg <= 32'h0000_0000;
            pend_erase_reg <= 1'b0;
            pend_sect_reg <= '0;
            o_busy <= 1'b0;
        end
        else if (i_clk_en)
        begin
            if (exec_wr_nv || exec_er_nv)
            begin
                busy_cnt_reg <= exec_er_nv ? 32'(ERASE_CYC) : 32'(PROG_CYC);
                pend_erase_reg <= exec_er_nv;
                pend_sect_reg <= sect_of(addr_reg);
                o_busy <= 1'b1;
            end
            else if (busy_cnt_reg != '0)
            begin
                busy_cnt_reg <= busy_cnt_reg - 32'h0000_0001;
                o_busy <= (busy_cnt_reg != 32'h0000_0001);
            end
        end
    end

    // persistent bits: no reset, so they outlive every reset
    always_ff @(posedge i_sys_clk)
    begin
        if (i_clk_en && busy_cnt_reg == 32'h0000_0001)
        begin
            if (pend_erase_reg)
            begin
                for (int i = 0; i < SECTORS; i++)
                    nv_bits[i] <= SLP_NV_UNLOCKED;
            end
            else
                nv_bits[pend_sect_reg] <= 1'b0;
        end
    end

    // program/erase permission answer, one cycle after the query
    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_pe_rsp <= '0;
        else if (i_clk_en)
        begin
            o_pe_rsp.done <= i_pe_req.valid;
            o_pe_rsp.allow <= i_pe_req.valid
                              && (nv_bits[sect_of(i_pe_req.addr)] == SLP_NV_UNLOCKED)
                              && !tmp_reg[tmp_idx(i_pe_req.addr)][SLP_WLOCK_BIT];
        end
    end

endmodule

/* File: rtl/slp_pkg.sv */
// constants, command codes and carrier types for the sector lock protection block
package slp_pkg;

    // array geometry
    localparam int SLP_SECTORS = 1024;
    localparam int SLP_SUBS_PER_EDGE = 16;
    localparam int SLP_SECT_LSB = 16;
    localparam int SLP_SUB_LSB = 12;
    localparam int SLP_ADDR_BYTES = 4;

    // link input synchroniser depth
    localparam int SLP_SYNC_STAGES = 3;

    // timing: clock period and operation times in ns, cycle counts derived
    localparam int SLP_CLK_NS = 10;
    localparam int SLP_BYTE_PROG_NS = 120_000;
    localparam int SLP_SECT_ERASE_NS = 150_000_000;
    localparam int SLP_PROG_CYC = (SLP_BYTE_PROG_NS + SLP_CLK_NS - 1) / SLP_CLK_NS;
    localparam int SLP_ERASE_CYC = (SLP_SECT_ERASE_NS + SLP_CLK_NS - 1) / SLP_CLK_NS;

    // temporary lock register fields and values after reset
    localparam int SLP_WLOCK_BIT = 0;
    localparam int SLP_LDOWN_BIT = 1;
    localparam logic [1:0] SLP_TMP_RESET = 2'h0;
    localparam logic SLP_NV_UNLOCKED = 1'b1;
    localparam logic [7:0] SLP_NV_RD_LOCKED = 8'h00;
    localparam logic [7:0] SLP_NV_RD_OPEN = 8'hFF;

    // command codes
    localparam logic [7:0] SLP_CMD_WR_TMP = 8'hE1;
    localparam logic [7:0] SLP_CMD_RD_TMP = 8'hE8;
    localparam logic [7:0] SLP_CMD_RD_NV = 8'hE2;
    localparam logic [7:0] SLP_CMD_WR_NV = 8'hE3;
    localparam logic [7:0] SLP_CMD_ER_NV = 8'hE4;

    // frame decoder states
    typedef enum logic [2:0] {
        SLP_ST_CMD,
        SLP_ST_ADDR,
        SLP_ST_DATA,
        SLP_ST_READ,
        SLP_ST_SKIP
    } slp_state_t;

    // program/erase permission query and its answer
    typedef struct packed {
        logic valid;
        logic [31:0] addr;
    } slp_pe_req_t;

    typedef struct packed {
        logic done;
        logic allow;
    } slp_pe_rsp_t;

endpackage

/* File: bench/slp_sector_lock_sva.sv */
// port-level checks for the sector lock protection block
`timescale 1ns/1ps
module slp_sector_lock_sva
    import slp_pkg::*;
#(
    parameter int PROG_CYC = SLP_PROG_CYC,
    parameter int ERASE_CYC = SLP_ERASE_CYC
)
(
    // clock, resets, enable
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_clk_en,
    input wire logic i_soft_reset,
    // link pins
    input wire logic i_spi_sck,
    input wire logic i_spi_cs_n,
    input wire logic i_spi_mosi,
    input wire logic o_spi_miso,
    input wire logic o_spi_miso_oe,
    // freeze, query and busy
    input wire logic i_global_freeze,
    input wire slp_pe_req_t i_pe_req,
    input wire slp_pe_rsp_t o_pe_rsp,
    input wire logic o_busy
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);

    // length of the current busy run; a counter avoids a huge repetition
    int busy_len;
    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            busy_len <= 0;
        else if (!o_busy)
            busy_len <= 0;
        else if (i_clk_en)
            busy_len <= busy_len + 1; // a frozen clock must not stretch the run
    end

    AST_QRY_ANSWER: assert property (i_pe_req.valid && i_clk_en |=> o_pe_rsp.done)
        else $error("query not answered next cycle");
    AST_QRY_NO_SPUR: assert property (!i_pe_req.valid && i_clk_en |=> !o_pe_rsp.done)
        else $error("answer without a query");
    AST_ALLOW_DONE: assert property (o_pe_rsp.allow |-> o_pe_rsp.done)
        else $error("allow outside an answer");
    AST_BUSY_MAX: assert property (busy_len <= ERASE_CYC)
        else $error("busy longer than an erase");
    AST_BUSY_LEN: assert property ($fell(o_busy) |-> busy_len == PROG_CYC || busy_len == ERASE_CYC)
        else $error("busy run of wrong length");
    AST_FREEZE: assert property ($rose(o_busy) |-> $past(i_global_freeze))
        else $error("persistent change started while frozen");
    AST_BUSY_CS: assert property ($rose(o_busy) |-> i_spi_cs_n && $past(i_spi_cs_n, 2))
        else $error("busy started inside a frame");
    AST_OE_IDLE: assert property (i_spi_cs_n [*6] |-> !o_spi_miso_oe)
        else $error("output driven between frames");
    AST_MISO_EDGE: assert property ($changed(o_spi_miso) && o_spi_miso_oe |-> !i_spi_sck)
        else $error("read data changed while link clock high");
    AST_FROZEN: assert property (!i_clk_en |=> $stable(o_pe_rsp) && $stable(o_busy))
        else $error("outputs moved while the clock enable was low");

    // main scenarios
    cover property (i_pe_req.valid ##1 o_pe_rsp.done && !o_pe_rsp.allow);
    cover property ($fell(o_busy) && busy_len == PROG_CYC);
    cover property ($rose(o_spi_miso_oe));
    cover property ($fell(o_busy) && busy_len == ERASE_CYC);
endmodule

bind slp_sector_lock slp_sector_lock_sva #(.PROG_CYC(PROG_CYC), .ERASE_CYC(ERASE_CYC)) u_sva (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_clk_en(i_clk_en),
    .i_soft_reset(i_soft_reset), .i_spi_sck(i_spi_sck), .i_spi_cs_n(i_spi_cs_n),
    .i_spi_mosi(i_spi_mosi), .o_spi_miso(o_spi_miso), .o_spi_miso_oe(o_spi_miso_oe),
    .i_global_freeze(i_global_freeze), .i_pe_req(i_pe_req), .o_pe_rsp(o_pe_rsp),
    .o_busy(o_busy));

/* File: bench/slp_host_model.sv */
// host side of the serial link: frames in mode 0, link clock still between frames
`timescale 1ns/1ps
module slp_host_model #(
    parameter int HALF = 6
)
(
    // system clock and read data
    input wire logic i_sys_clk,
    input wire logic i_spi_miso,
    // link outputs
    output logic o_spi_sck,
    output logic o_spi_cs_n,
    output logic o_spi_mosi
);
    initial
    begin
        o_spi_sck = 1'b0;
        o_spi_cs_n = 1'b1;
        o_spi_mosi = 1'b0;
    end

    // n bits of v msb first; read data taken at each rising link edge
    task automatic xfer(input logic [47:0] v, input int n, output logic [7:0] q);
        q = 8'h00;
        repeat (8) @(posedge i_sys_clk);
        o_spi_cs_n <= 1'b0;
        for (int i = 0; i < n; i++)
        begin
            o_spi_mosi <= v[47 - i];
            repeat (HALF) @(posedge i_sys_clk);
            o_spi_sck <= 1'b1;
            q = {q[6:0], i_spi_miso};
            repeat (HALF) @(posedge i_sys_clk);
            o_spi_sck <= 1'b0;
        end
        repeat (HALF) @(posedge i_sys_clk);
        o_spi_cs_n <= 1'b1;
        o_spi_mosi <= ~o_spi_mosi; // idle line never repeats stale data
    endtask
endmodule

/* File: bench/slp_sector_lock_test.sv */
// self-checking bench: lock commands over the link, permission queries
`timescale 1ns/1ps
module slp_sector_lock_test;
    import slp_pkg::*;
    localparam int PROG = 20;
    localparam int ERASE = 50;
    logic i_sys_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_soft_reset = 1'b0;
    logic clk_en = 1'b1;
    logic i_global_freeze = 1'b1;
    slp_pe_req_t i_pe_req = '0;
    slp_pe_rsp_t o_pe_rsp;
    logic sck, cs_n, mosi, miso, busy;
    logic [7:0] q;
    int bad_count = 0;
    int comparisons = 0;

    // 100 MHz clock
    always #5 i_sys_clk = ~i_sys_clk;

    slp_sector_lock #(.SECTORS(4), .PROG_CYC(PROG), .ERASE_CYC(ERASE)) dut (
        .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_clk_en(clk_en),
        .i_soft_reset(i_soft_reset), .i_spi_sck(sck), .i_spi_cs_n(cs_n),
        .i_spi_mosi(mosi), .o_spi_miso(miso), .o_spi_miso_oe(),
        .i_global_freeze(i_global_freeze), .i_pe_req(i_pe_req), .o_pe_rsp(o_pe_rsp),
        .o_busy(busy));
    slp_host_model host (.i_sys_clk(i_sys_clk), .i_spi_miso(miso), .o_spi_sck(sck),
        .o_spi_cs_n(cs_n), .o_spi_mosi(mosi));

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp)
        begin
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
            bad_count++;
        end
    endtask
    task automatic rd(input logic [7:0] op, input logic [31:0] a, input logic [7:0] exp);
        host.xfer({op, a, 8'h00}, 48, q);
        chk("read byte", exp, q);
    endtask
    task automatic wr(input logic [7:0] op, input logic [31:0] a, input logic [7:0] d, input int n);
        host.xfer({op, a, d}, n, q);
    endtask
    // answer is registered: visible at the second edge after the pulse
    task automatic qry(input logic [31:0] a, input logic exp);
        @(posedge i_sys_clk);
        i_pe_req <= '{valid: 1'b1, addr: a};
        @(posedge i_sys_clk);
        i_pe_req <= '0;
        @(posedge i_sys_clk);
        chk("done and allow", {6'h00, 1'b1, exp}, {6'h00, o_pe_rsp.done, o_pe_rsp.allow});
    endtask
    // counts busy cycles; a busy still high after 200 cycles fails the wait
    task automatic wait_busy(input int exp);
        int n;
        n = 0;
        for (int i = 0; i < 200 && !(n > 0 && busy === 1'b0); i++)
        begin
            @(posedge i_sys_clk);
            if (busy === 1'b1)
                n++;
        end
        // still busy after the bound: the wait has run out
        if (busy !== 1'b0)
        begin
            $display("[FAIL] busy wait expected 0 seen %b", busy);
            bad_count++;
            wrap_up;
        end
        chk("busy cycles", exp[7:0], n[7:0]);
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // hang guard
    initial
    begin
        repeat (90000) @(posedge i_sys_clk);
        bad_count++;
        wrap_up;
    end

    // main sequence
    initial
    begin
        repeat (12) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        wr(SLP_CMD_ER_NV, 32'h0000_0000, 8'h00, 8);
        wait_busy(ERASE);
        for (int s = 0; s < 4; s++)
            rd(SLP_CMD_RD_NV, {14'h0000, s[1:0], 16'h0000}, SLP_NV_RD_OPEN);
        $display("erase test done");
        i_global_freeze <= 1'b0;
        wr(SLP_CMD_WR_NV, 32'h0001_0000, 8'h00, 40);
        wait_busy(0);
        rd(SLP_CMD_RD_NV, 32'h0001_0000, SLP_NV_RD_OPEN);
        i_global_freeze <= 1'b1;
        wr(SLP_CMD_WR_NV, 32'h0001_0000, 8'h00, 40);
        wait_busy(PROG);
        rd(SLP_CMD_RD_NV, 32'h0001_0000, SLP_NV_RD_LOCKED);
        rd(SLP_CMD_RD_NV, 32'h0002_0000, SLP_NV_RD_OPEN);
        qry(32'h0001_0040, 1'b0);
        qry(32'h0002_0040, 1'b1);
        $display("persistent test done");
        rd(SLP_CMD_RD_TMP, 32'h0002_0000, 8'h00);
        wr(SLP_CMD_WR_TMP, 32'h0002_0000, 8'h01, 48);
        rd(SLP_CMD_RD_TMP, 32'h0002_0000, 8'h01);
        qry(32'h0002_0100, 1'b0);
        wr(SLP_CMD_WR_TMP, 32'h0002_0000, 8'hFF, 48);
        rd(SLP_CMD_RD_TMP, 32'h0002_0000, 8'h03);
        wr(SLP_CMD_WR_TMP, 32'h0002_0000, 8'h00, 48);
        rd(SLP_CMD_RD_TMP, 32'h0002_0000, 8'h03);
        qry(32'h0002_0100, 1'b0);
        wr(SLP_CMD_WR_TMP, 32'h0003_1000, 8'h01, 48);
        rd(SLP_CMD_RD_TMP, 32'h0003_2000, 8'h00);
        qry(32'h0003_1FFC, 1'b0);
        qry(32'h0003_2000, 1'b1);
        // a query with the clock enable low must not be answered
        @(posedge i_sys_clk);
        clk_en <= 1'b0;
        i_pe_req <= '{valid: 1'b1, addr: 32'h0002_0040};
        @(posedge i_sys_clk);
        i_pe_req <= '0;
        @(posedge i_sys_clk);
        clk_en <= 1'b1;
        chk("frozen answer", 8'h00, {6'h00, o_pe_rsp.done, o_pe_rsp.allow});
        $display("temporary test done");
        i_soft_reset <= 1'b1;
        @(posedge i_sys_clk);
        i_soft_reset <= 1'b0;
        rd(SLP_CMD_RD_TMP, 32'h0002_0000, 8'h00);
        qry(32'h0003_1000, 1'b1);
        wr(8'h00, 32'h0002_0000, 8'h01, 48);
        rd(SLP_CMD_RD_TMP, 32'h0002_0000, 8'h00);
        wr(SLP_CMD_WR_TMP, 32'h0002_0000, 8'h01, 44);
        rd(SLP_CMD_RD_TMP, 32'h0002_0000, 8'h00);
        wr(SLP_CMD_WR_TMP, 32'h0002_0000, 8'h01, 48);
        rd(SLP_CMD_RD_TMP, 32'h0002_0000, 8'h01);
        i_rst_n <= 1'b0;
        repeat (2) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        rd(SLP_CMD_RD_TMP, 32'h0002_0000, 8'h00);
        rd(SLP_CMD_RD_NV, 32'h0001_0000, SLP_NV_RD_LOCKED);
        qry(32'h0001_0000, 1'b0);
        i_global_freeze <= 1'b0;
        wr(SLP_CMD_ER_NV, 32'h0000_0000, 8'h00, 8);
        wait_busy(0);
        rd(SLP_CMD_RD_NV, 32'h0001_0000, SLP_NV_RD_LOCKED);
        i_global_freeze <= 1'b1;
        wr(SLP_CMD_ER_NV, 32'h0000_0000, 8'h00, 8);
        wait_busy(ERASE);
        rd(SLP_CMD_RD_NV, 32'h0001_0000, SLP_NV_RD_OPEN);
        $display("reset test done");
        wrap_up;
    end
endmodule
